// ---- rtl/swrcl_pkg.sv ----
package swrcl_pkg;

   // Core clock rate, used to turn every time below into cycles
   localparam int CLK_MHZ = 20;

   // Slot timing, standard and fast speed, in microseconds
   localparam int T_SAMPLE_STD_US = 30;
   localparam int T_SAMPLE_OD_US = 3;
   localparam int T_HOLD_STD_US = 30;
   localparam int T_HOLD_OD_US = 3;
   localparam int T_PDH_STD_US = 15;
   localparam int T_PDH_OD_US = 2;
   localparam int T_PDL_STD_US = 120;
   localparam int T_PDL_OD_US = 12;
   localparam int T_RST_STD_US = 200;
   localparam int T_RST_OD_US = 40;
   localparam int T_OD_KEEP_US = 80;
   localparam int T_OD_EXIT_US = 690;

   // Derived cycle counts
   localparam int SAMPLE_STD_CYC = T_SAMPLE_STD_US * CLK_MHZ;
   localparam int SAMPLE_OD_CYC = T_SAMPLE_OD_US * CLK_MHZ;
   localparam int HOLD_STD_CYC = T_HOLD_STD_US * CLK_MHZ;
   localparam int HOLD_OD_CYC = T_HOLD_OD_US * CLK_MHZ;
   localparam int PDH_STD_CYC = T_PDH_STD_US * CLK_MHZ;
   localparam int PDH_OD_CYC = T_PDH_OD_US * CLK_MHZ;
   localparam int PDL_STD_CYC = T_PDL_STD_US * CLK_MHZ;
   localparam int PDL_OD_CYC = T_PDL_OD_US * CLK_MHZ;
   localparam int RST_STD_CYC = T_RST_STD_US * CLK_MHZ;
   localparam int RST_OD_CYC = T_RST_OD_US * CLK_MHZ;
   localparam int OD_KEEP_CYC = T_OD_KEEP_US * CLK_MHZ;
   localparam int OD_EXIT_CYC = T_OD_EXIT_US * CLK_MHZ;

   localparam int CNT_W = 15;

   // Command codes of the addressing layer
   localparam logic [7:0] CMD_READ_ID = 8'h33;
   localparam logic [7:0] CMD_MATCH = 8'h55;
   localparam logic [7:0] CMD_SEARCH = 8'hF0;
   localparam logic [7:0] CMD_COND_SEARCH = 8'hEC;
   localparam logic [7:0] CMD_SKIP = 8'hCC;
   localparam logic [7:0] CMD_RESUME = 8'hA5;
   localparam logic [7:0] CMD_FAST_SKIP = 8'h3C;
   localparam logic [7:0] CMD_FAST_MATCH = 8'h69;

   // Alarm status register and its fields
   localparam logic [15:0] ADDR_ALARM_FLAGS_STATUS = 16'h0214;
   localparam logic [7:0] ALARM_FLAGS_RESET = 8'h00;
   localparam int ALM_TEMP_LOW = 0;
   localparam int ALM_TEMP_HIGH = 1;
   localparam int ALM_HUM_LOW = 2;
   localparam int ALM_HUM_HIGH = 3;
   localparam int ALM_BROWNOUT = 4;
   localparam int ALM_N = 5;

   localparam logic [6:0] LAST_ID_BIT = 7'h3F;
   localparam logic [6:0] LAST_BYTE_BIT = 7'h07;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;

   typedef enum logic [2:0] {
      SLOT_IDLE, SLOT_LOW, SLOT_PDH, SLOT_PDL, SLOT_REC
   } swrcl_slot_t;

   typedef enum logic [2:0] {
      ROM_WAIT_RST, ROM_CMD, ROM_READ, ROM_MATCH, ROM_SEARCH, ROM_FUNC
   } swrcl_rom_t;

   // Whole state of the block
   typedef struct packed {
      logic [2:0] sync;
      logic dq_f;
      swrcl_slot_t slot;
      logic [CNT_W-1:0] cnt;
      logic fired;
      logic drv;
      logic od;
      logic od_prev;
      logic resume_select_flag;
      swrcl_rom_t rom;
      logic [7:0] sh;
      logic [6:0] idx;
      logic [1:0] ph;
      logic miss;
      logic [ALM_N-1:0] alarm;
      logic [7:0] rdata;
      logic [1:0] fcnt;
      logic [7:0] f0;
      logic [7:0] f1;
   } swrcl_state_t;

endpackage

// ---- rtl/swrcl_rom_layer.sv ----
`timescale 1ns/100ps

module swrcl_rom_layer
   import swrcl_pkg::*;
#(
   parameter logic [7:0] P_FAMILY = 8'h5A,        // Arbitrary value
   parameter logic [47:0] P_SERIAL = 48'h0123456789AB, // Arbitrary value
   parameter logic [7:0] P_CRC = 8'hC3,           // Arbitrary value
   parameter int P_OD_EXIT_CYC = OD_EXIT_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_dq,
   output logic o_dq_o,
   output logic o_dq_oe_n,
   input wire logic [ALM_N-1:0] i_alarm_evt,
   input wire logic [ALM_N-2:0] i_alarm_en,
   input wire logic i_alarm_clr,
   input wire logic [15:0] i_mem_addr,
   output logic [7:0] o_mem_rdata,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   input wire logic i_rx_ready,
   output logic o_func_active,
   output logic o_fast_speed_flag,
   output logic o_resume_select_flag
);

   localparam logic [63:0] ID = {P_CRC, P_SERIAL, P_FAMILY};

   swrcl_state_t s_r;
   swrcl_state_t s_nxt;

   // Pick a cycle count by speed, cut to the counter width
   function automatic logic [CNT_W-1:0] by_speed(input logic fast, input int std_c,
                                                 input int od_c);
      by_speed = fast ? CNT_W'(od_c) : CNT_W'(std_c);
   endfunction

   // Registration bit at an index, family LSB first
   function automatic logic id_bit(input logic [6:0] idx);
      id_bit = ID[idx[5:0]];
   endfunction

   logic fall;
   logic rise;
   logic slot_evt;
   logic rx_bit;
   logic rst_evt;
   logic tx_zero;
   logic fifo_full;
   logic pop;
   logic [7:0] byte_in;
   logic [ALM_N-1:0] alarm_arm;

   // Transmit decision taken at slot start; only a zero ever pulls the line
   always_comb begin
      tx_zero = 1'b0;
      case (s_r.rom)
         ROM_READ: begin
            tx_zero = !id_bit(s_r.idx);
         end
         ROM_SEARCH: begin
            if (s_r.ph == 2'h0) begin
               tx_zero = !id_bit(s_r.idx);
            end else if (s_r.ph == 2'h1) begin
               tx_zero = id_bit(s_r.idx);
            end
         end
         default: begin
            tx_zero = 1'b0;
         end
      endcase
   end

   assign fifo_full = (s_r.fcnt == FIFO_DEPTH);
   assign pop = i_rx_ready && (s_r.fcnt != 2'h0);
   assign byte_in = {rx_bit, s_r.sh[7:1]};
   // Brownout cannot be masked
   assign alarm_arm = {1'b1, i_alarm_en};

   always_comb begin
      s_nxt = s_r;
      fall = 1'b0;
      rise = 1'b0;
      slot_evt = 1'b0;
      rst_evt = 1'b0;
      rx_bit = s_r.dq_f;

      // Three-stage input; the filtered level only moves when stages 2 and 3 agree
      s_nxt.sync = {s_r.sync[1:0], i_dq};
      if (s_r.sync[2] == s_r.sync[1]) begin
         s_nxt.dq_f = s_r.sync[2];
      end
      fall = s_r.dq_f && !s_nxt.dq_f;
      rise = !s_r.dq_f && s_nxt.dq_f;

      // Slot timer: started only by the master's falling edge
      case (s_r.slot)
         SLOT_IDLE: begin
            if (fall) begin
               s_nxt.slot = SLOT_LOW;
               s_nxt.cnt = '0;
               s_nxt.fired = 1'b0;
               s_nxt.drv = tx_zero && !fifo_full;
            end
         end
         SLOT_LOW: begin
            if (s_r.cnt != {CNT_W{1'b1}}) begin
               s_nxt.cnt = s_r.cnt + CNT_W'(1);
            end
            if (s_r.cnt == by_speed(s_r.od, HOLD_STD_CYC, HOLD_OD_CYC)) begin
               s_nxt.drv = 1'b0;
            end
            // Sample point; a held zero from us reads back as our own bit
            if (!s_r.fired && s_r.cnt == by_speed(s_r.od, SAMPLE_STD_CYC, SAMPLE_OD_CYC)) begin
               s_nxt.fired = 1'b1;
               slot_evt = 1'b1;
            end
            // A one bit lets the line rise before the sample point, so the slot
            // runs on and only closes once its bit is taken and the line is high.
            // A reset low also passes the sample point; the stray bit it leaves
            // behind is undone by the restart below unless it ends a byte, a match or a search step.
            if (rise && s_r.cnt >= by_speed(s_r.od, RST_STD_CYC, RST_OD_CYC)) begin
               s_nxt.drv = 1'b0;
               rst_evt = 1'b1;
               s_nxt.slot = SLOT_PDH;
               s_nxt.cnt = '0;
               // Long reset returns to standard; a short fast reset keeps speed
               if (s_r.cnt >= CNT_W'(P_OD_EXIT_CYC)) begin
                  s_nxt.od = 1'b0;
               end
            end else if (s_nxt.dq_f && (s_r.fired || slot_evt)) begin
               s_nxt.drv = 1'b0;
               s_nxt.slot = SLOT_IDLE;
            end
         end
         SLOT_PDH: begin
            s_nxt.cnt = s_r.cnt + CNT_W'(1);
            if (s_r.cnt >= by_speed(s_r.od, PDH_STD_CYC, PDH_OD_CYC)) begin
               s_nxt.slot = SLOT_PDL;
               s_nxt.cnt = '0;
               s_nxt.drv = 1'b1;
            end
         end
         SLOT_PDL: begin
            s_nxt.cnt = s_r.cnt + CNT_W'(1);
            if (s_r.cnt >= by_speed(s_r.od, PDL_STD_CYC, PDL_OD_CYC)) begin
               s_nxt.drv = 1'b0;
               s_nxt.slot = SLOT_REC;
            end
         end
         SLOT_REC: begin
            // Our own presence low must not look like a master slot start
            if (s_r.dq_f) begin
               s_nxt.slot = SLOT_IDLE;
            end
         end
         default: begin
            s_nxt.slot = SLOT_IDLE;
            s_nxt.drv = 1'b0;
         end
      endcase

      // Addressing layer, advanced once per slot; stalls while the buffer is full
      if (slot_evt && !fifo_full) begin
         case (s_r.rom)
            ROM_CMD: begin
               s_nxt.sh = byte_in;
               s_nxt.idx = s_r.idx + 7'h01;
               if (s_r.idx == LAST_BYTE_BIT) begin
                  s_nxt.idx = '0;
                  s_nxt.ph = 2'h0;
                  s_nxt.miss = 1'b0;
                  s_nxt.od_prev = s_r.od;
                  case (byte_in)
                     CMD_READ_ID: s_nxt.rom = ROM_READ;
                     CMD_MATCH: s_nxt.rom = ROM_MATCH;
                     CMD_SEARCH: s_nxt.rom = ROM_SEARCH;
                     CMD_COND_SEARCH: begin
                        s_nxt.rom = (|s_r.alarm) ? ROM_SEARCH : ROM_WAIT_RST;
                     end
                     CMD_SKIP: s_nxt.rom = ROM_FUNC;
                     CMD_RESUME: begin
                        s_nxt.rom = s_r.resume_select_flag ? ROM_FUNC : ROM_WAIT_RST;
                     end
                     CMD_FAST_SKIP: begin
                        s_nxt.od = 1'b1;
                        s_nxt.rom = ROM_FUNC;
                     end
                     CMD_FAST_MATCH: begin
                        // Address bits that follow arrive at fast speed
                        s_nxt.od = 1'b1;
                        s_nxt.rom = ROM_MATCH;
                     end
                     default: s_nxt.rom = ROM_WAIT_RST;
                  endcase
               end
            end
            ROM_READ: begin
               s_nxt.idx = s_r.idx + 7'h01;
               if (s_r.idx == LAST_ID_BIT) begin
                  s_nxt.rom = ROM_FUNC;
                  s_nxt.idx = '0;
               end
            end
            ROM_MATCH: begin
               s_nxt.idx = s_r.idx + 7'h01;
               s_nxt.miss = s_r.miss || (rx_bit != id_bit(s_r.idx));
               if (s_r.idx == LAST_ID_BIT) begin
                  s_nxt.idx = '0;
                  if (s_nxt.miss) begin
                     s_nxt.rom = ROM_WAIT_RST;
                     s_nxt.resume_select_flag = 1'b0;
                     s_nxt.od = s_r.od_prev;
                  end else begin
                     s_nxt.rom = ROM_FUNC;
                     s_nxt.resume_select_flag = 1'b1;
                  end
               end
            end
            ROM_SEARCH: begin
               if (s_r.ph != 2'h2) begin
                  s_nxt.ph = s_r.ph + 2'h1;
               end else begin
                  s_nxt.ph = 2'h0;
                  if (rx_bit != id_bit(s_r.idx)) begin
                     s_nxt.rom = ROM_WAIT_RST;
                     s_nxt.resume_select_flag = 1'b0;
                  end else if (s_r.idx == LAST_ID_BIT) begin
                     s_nxt.rom = ROM_FUNC;
                     s_nxt.idx = '0;
                     s_nxt.resume_select_flag = 1'b1;
                  end else begin
                     s_nxt.idx = s_r.idx + 7'h01;
                  end
               end
            end
            ROM_FUNC: begin
               s_nxt.sh = byte_in;
               s_nxt.idx = s_r.idx + 7'h01;
               if (s_r.idx == LAST_BYTE_BIT) begin
                  s_nxt.idx = '0;
               end
            end
            default: begin
               s_nxt.rom = s_r.rom;
            end
         endcase
      end

      // Reset pulse restarts the addressing layer whatever it was doing
      if (rst_evt) begin
         s_nxt.rom = ROM_CMD;
         s_nxt.idx = '0;
         s_nxt.ph = 2'h0;
         s_nxt.miss = 1'b0;
      end

      // Two-entry buffer of function-phase bytes; push and pop may share a cycle
      if (pop) begin
         s_nxt.f0 = s_r.f1;
      end
      if (slot_evt && !fifo_full && s_r.rom == ROM_FUNC && s_r.idx == LAST_BYTE_BIT
          && !rst_evt) begin
         if (s_r.fcnt == 2'h0 || (s_r.fcnt == 2'h1 && pop)) begin
            s_nxt.f0 = byte_in;
         end else begin
            s_nxt.f1 = byte_in;
         end
         s_nxt.fcnt = pop ? s_r.fcnt : s_r.fcnt + 2'h1;
      end else if (pop) begin
         s_nxt.fcnt = s_r.fcnt - 2'h1;
      end

      // Alarm flags: a new event wins over a clear in the same cycle
      s_nxt.alarm = (i_alarm_clr ? '0 : s_r.alarm) | (i_alarm_evt & alarm_arm);

      // Register read port
      s_nxt.rdata = (i_mem_addr == ADDR_ALARM_FLAGS_STATUS) ? {3'h0, s_r.alarm} : 8'h00;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         s_r <= '0;
         s_r.sync <= 3'h7;
         s_r.dq_f <= 1'b1;
         s_r.slot <= SLOT_IDLE;
         s_r.rom <= ROM_WAIT_RST;
         s_r.alarm <= ALARM_FLAGS_RESET[ALM_N-1:0];
      end else if (i_clk_en) begin
         s_r <= s_nxt;
      end
   end

   // Open drain: the pin only ever pulls low
   assign o_dq_o = 1'b0;
   assign o_dq_oe_n = !s_r.drv;
   assign o_mem_rdata = s_r.rdata;
   assign o_rx_valid = (s_r.fcnt != 2'h0);
   assign o_rx_data = s_r.f0;
   assign o_func_active = (s_r.rom == ROM_FUNC);
   assign o_fast_speed_flag = s_r.od;
   assign o_resume_select_flag = s_r.resume_select_flag;

endmodule

// ---- tb/swrcl_master_model.sv ----
`timescale 1ns/100ps
// Bus master: starts every slot, idles the line high in between
module swrcl_master_model (
   input wire logic i_core_clk,
   input wire logic i_line,
   output logic o_pull
);
   int fast = 0;
   initial o_pull = 1'b0;
   // Pull for lo cycles, then release for hi cycles
   task automatic pulse(input int lo, input int hi);
      @(posedge i_core_clk);
      #2 o_pull = 1'b1;
      repeat (lo) @(posedge i_core_clk);
      #2 o_pull = 1'b0;
      repeat (hi) @(posedge i_core_clk);
   endtask
   // Slot lows stay well short of the reset length of their own speed
   task automatic wr(input logic b);
      if (fast) pulse(b ? 5 : 80, b ? 95 : 20);
      else pulse(b ? 60 : 800, b ? 740 : 100);
   endtask
   task automatic wr_byte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) wr(v[i]);
   endtask
   task automatic wr_id(input logic [63:0] v);
      for (int i = 0; i < 64; i++) wr(v[i]);
   endtask
   // Short low, then sample inside the device hold
   task automatic rd(output logic b);
      pulse(5, fast ? 30 : 300);
      #1 b = i_line;
      repeat (fast ? 65 : 1100) @(posedge i_core_clk);
   endtask
   // Reset pulse, then watch for presence
   task automatic rst(input int lo, output logic seen);
      seen = 1'b0;
      pulse(lo, 0);
      repeat (fast ? 400 : 3500) begin
         @(posedge i_core_clk);
         #1;
         if (i_line === 1'b0) seen = 1'b1;
      end
   endtask
endmodule

// ---- tb/swrcl_rom_layer_chk.sv ----
`timescale 1ns/100ps
module swrcl_rom_layer_chk
   import swrcl_pkg::*;
#(
   parameter int P_OD_EXIT_CYC = OD_EXIT_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_dq,
   input wire logic o_dq_o,
   input wire logic o_dq_oe_n,
   input wire logic [ALM_N-1:0] i_alarm_evt,
   input wire logic [ALM_N-2:0] i_alarm_en,
   input wire logic i_alarm_clr,
   input wire logic [15:0] i_mem_addr,
   input wire logic [7:0] o_mem_rdata,
   input wire logic o_rx_valid,
   input wire logic [7:0] o_rx_data,
   input wire logic i_rx_ready,
   input wire logic o_func_active,
   input wire logic o_fast_speed_flag,
   input wire logic o_resume_select_flag
);
   // Margin covers the input synchroniser lag
   localparam int EXIT_SURE = P_OD_EXIT_CYC + 8;
   localparam int DRV_MAX = PDL_STD_CYC + 4;
   logic [15:0] low_cnt_r;
   logic [15:0] drv_cnt_r;

   // Run lengths of a low line and of the device's own pull
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         low_cnt_r <= 16'h0000;
         drv_cnt_r <= 16'h0000;
      end else begin
         if (i_dq) low_cnt_r <= 16'h0000;
         else if (low_cnt_r != 16'hFFFF) low_cnt_r <= low_cnt_r + 16'h0001;
         drv_cnt_r <= o_dq_oe_n ? 16'h0000 : drv_cnt_r + 16'h0001;
      end
   end

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   sequence raise_read_s;
      i_clk_en && i_alarm_evt[ALM_BROWNOUT] ##1
         i_clk_en && !i_alarm_clr && i_mem_addr == ADDR_ALARM_FLAGS_STATUS;
   endsequence
   sequence clear_read_s;
      i_clk_en && i_alarm_clr && i_alarm_evt == 5'h00 ##1
         i_clk_en && i_mem_addr == ADDR_ALARM_FLAGS_STATUS;
   endsequence

   drive_low_only_a: assert property (o_dq_o == 1'b0)
      else $error("pin output value not low");
   unmapped_zero_a: assert property (
      i_clk_en && i_mem_addr != ADDR_ALARM_FLAGS_STATUS |=> o_mem_rdata == 8'h00)
      else $error("unmapped read not zero");
   unused_bits_a: assert property (
      i_clk_en && i_mem_addr == ADDR_ALARM_FLAGS_STATUS |=> o_mem_rdata[7:ALM_N] == 3'h0)
      else $error("alarm status upper bits set");
   brownout_latch_a: assert property (raise_read_s |=> o_mem_rdata[ALM_BROWNOUT])
      else $error("brownout alarm not latched");
   alarm_clear_a: assert property (clear_read_s |=> o_mem_rdata == 8'h00)
      else $error("alarm flags not cleared");
   rx_hold_a: assert property (
      o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
      else $error("buffered byte lost while stalled");
   resume_select_a: assert property (
      $rose(o_resume_select_flag) |-> ##[0:2] o_func_active)
      else $error("resume flag set without selection");
   short_keep_a: assert property (
      o_fast_speed_flag && i_dq && low_cnt_r > RST_OD_CYC && low_cnt_r <= OD_KEEP_CYC
      |=> o_fast_speed_flag [*8])
      else $error("short reset left fast speed");
   long_exit_a: assert property (
      i_dq && low_cnt_r >= EXIT_SURE |-> ##[1:12] !o_fast_speed_flag)
      else $error("long reset kept fast speed");
   pull_length_a: assert property (drv_cnt_r <= DRV_MAX)
      else $error("device pull too long");
endmodule

// ---- tb/swrcl_rom_layer_tb.sv ----
`timescale 1ns/100ps
module swrcl_rom_layer_tb;
   import swrcl_pkg::*;
   localparam logic [7:0] FAM = 8'h28; // Arbitrary value
   localparam logic [47:0] SER = 48'h9A3C5E71B20D; // Arbitrary value
   localparam logic [7:0] CRC = 8'h6E; // Arbitrary value
   localparam logic [63:0] ID = {CRC, SER, FAM};
   localparam int EXIT = 4100; // Shortened, still above the standard reset
   logic i_core_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_clk_en = 1'b1;
   logic pull;
   logic o_dq_o, o_dq_oe_n, o_rx_valid, o_func_active, o_fast_speed_flag, o_resume_select_flag;
   logic [ALM_N-1:0] i_alarm_evt = 5'h00;
   logic [ALM_N-2:0] i_alarm_en = 4'h0;
   logic i_alarm_clr = 1'b0;
   logic i_rx_ready = 1'b0;
   logic [15:0] i_mem_addr = 16'h0000;
   logic [7:0] o_mem_rdata, o_rx_data;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int exp_fast = 0;
   int exp_rc = 0;
   logic [7:0] q[$];
   // Open-drain line with pull-up
   wire i_dq = !(pull || !o_dq_oe_n);

   always #25 i_core_clk = !i_core_clk;

   swrcl_rom_layer #(.P_FAMILY(FAM), .P_SERIAL(SER), .P_CRC(CRC), .P_OD_EXIT_CYC(EXIT)) DUT (
      .i_core_clk, .i_sys_rst, .i_clk_en, .i_dq, .o_dq_o, .o_dq_oe_n, .i_alarm_evt, .i_alarm_en,
      .i_alarm_clr, .i_mem_addr, .o_mem_rdata, .o_rx_valid, .o_rx_data, .i_rx_ready,
      .o_func_active, .o_fast_speed_flag, .o_resume_select_flag);
   swrcl_master_model m (.i_core_clk, .i_line(i_dq), .o_pull(pull));

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Bus reset, presence, then a command byte
   task automatic cmd(input logic [7:0] c, input int lo);
      logic p;
      m.rst(lo, p);
      check("presence", p, 1'b1);
      m.wr_byte(c);
   endtask
   // Selection state against the model
   task automatic flags(input logic fn);
      #2;
      check("func", o_func_active, fn);
      check("fast", o_fast_speed_flag, exp_fast[0]);
      check("resume", o_resume_select_flag, exp_rc[0]);
   endtask
   task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge i_core_clk);
      #2 i_mem_addr = a;
      repeat (2) @(posedge i_core_clk);
      #1 check("rdata", o_mem_rdata, e);
   endtask
   task automatic evt(input int b);
      @(posedge i_core_clk);
      #2 i_alarm_evt = 5'h01 << b;
      @(posedge i_core_clk);
      #2 i_alarm_evt = 5'h00;
   endtask

   initial begin
      logic b;
      logic c;
      logic [63:0] got;
      void'($urandom(29358));
      repeat (5) @(posedge i_core_clk);
      #2 i_sys_rst = 1'b0;
      // Standard start, then fast timing until the closing long reset
      cmd(CMD_FAST_SKIP, 4200);
      exp_fast = 1;
      m.fast = 1;
      flags(1'b1);
      // Short reset keeps fast timing
      cmd(CMD_READ_ID, 900);
      for (int i = 0; i < 64; i++) m.rd(got[i]);
      check("read id", got, ID);
      flags(1'b1);
      // Disabled alarm ignored, enabled one and brownout latch
      reg_rd(16'h0215, 8'h00);
      reg_rd(ADDR_ALARM_FLAGS_STATUS, 8'h00);
      evt(ALM_TEMP_LOW);
      i_alarm_en = 4'h2;
      evt(ALM_TEMP_HIGH);
      evt(ALM_BROWNOUT);
      reg_rd(ADDR_ALARM_FLAGS_STATUS, 8'h12);
      cmd(CMD_COND_SEARCH, 900);
      for (int i = 0; i < 64; i++) begin
         m.rd(b);
         m.rd(c);
         check("search bit", {b, c}, {ID[i], !ID[i]});
         m.wr(ID[i]);
      end
      exp_rc = 1;
      flags(1'b1);
      // Third byte refused while the reader stalls
      cmd(CMD_RESUME, 900);
      flags(1'b1);
      for (int k = 0; k < 3; k++) begin
         got[7:0] = 8'($urandom);
         m.wr_byte(got[7:0]);
         if (k < 2) q.push_back(got[7:0]);
      end
      #2;
      for (int k = 0; k < 2; k++) begin
         check("rx valid", o_rx_valid, 1'b1);
         check("rx data", o_rx_data, q.pop_front());
         @(posedge i_core_clk);
         #2 i_rx_ready = 1'b1;
         @(posedge i_core_clk);
         #2 i_rx_ready = 1'b0;
      end
      check("rx empty", o_rx_valid, 1'b0);
      // Wrong code at fast match keeps speed, loses selection
      cmd(CMD_FAST_MATCH, 900);
      m.wr_id(ID ^ 64'h8000000000000000);
      exp_rc = 0;
      flags(1'b0);
      cmd(CMD_RESUME, 900);
      flags(1'b0);
      cmd(CMD_MATCH, 900);
      m.wr_id(ID);
      exp_rc = 1;
      flags(1'b1);
      // Wrong branch in a plain search drops out and clears the flag
      cmd(CMD_SEARCH, 900);
      m.rd(b);
      m.rd(c);
      check("search first", {b, c}, {ID[0], !ID[0]});
      m.wr(!ID[0]);
      m.rd(b);
      m.rd(c);
      exp_rc = 0;
      check("dropout", {b, c}, 2'h3);
      flags(1'b0);
      @(posedge i_core_clk);
      #2 i_alarm_clr = 1'b1;
      @(posedge i_core_clk);
      #2 i_alarm_clr = 1'b0;
      reg_rd(ADDR_ALARM_FLAGS_STATUS, 8'h00);
      cmd(CMD_COND_SEARCH, 900);
      m.rd(b);
      m.rd(c);
      check("idle search", {b, c}, 2'h3);
      cmd(8'h96, 900);
      m.rd(b);
      check("unknown", {b, o_func_active}, 2'h2);
      // Long reset returns to standard speed
      m.fast = 0;
      cmd(CMD_SKIP, 4200);
      #2;
      check("std skip", {o_fast_speed_flag, o_func_active}, 2'h1);
      give_verdict();
   end

   // Cycle ceiling above the planned run
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 100000) begin
         bad_count++;
         give_verdict();
      end
   end
endmodule

bind swrcl_rom_layer swrcl_rom_layer_chk #(.P_OD_EXIT_CYC(P_OD_EXIT_CYC)) u_chk (
   .i_core_clk, .i_sys_rst, .i_clk_en, .i_dq, .o_dq_o, .o_dq_oe_n, .i_alarm_evt, .i_alarm_en,
   .i_alarm_clr, .i_mem_addr, .o_mem_rdata, .o_rx_valid, .o_rx_data, .i_rx_ready,
   .o_func_active, .o_fast_speed_flag, .o_resume_select_flag);
